// ### inc/cid_defs.vh
// Purpose: constants of the interrupt dispatch block
// Assumes: one clock, aclk, 25 MHz; AXI4-Lite register access
// Notes: byte offsets, field positions, reset values
//
// How it works
// [R01] Any reset leaves global enable cleared
// [R02] Redirect needs global and own enables, plus group enable for peripheral flags
// [R03] Flags set on event regardless of enables
// [R04] Entry flushes, clears enable, saves, pushes, vectors
// [R05] During service, events flag but never redirect
// [R06] Return pops, restores context, sets global enable
// [R07] Pending enabled flag taken when enable returns
// [R08] Software clears handled flags before returning
// [R09] Software polls flags; one common vector
// [R10] Latency three to four instruction cycles
// [R11] Shadow covers work, status low, bank, pointers, latch
// [R12] Wake runs next instruction, then vectors if enabled
// [R13] Request is OR of enabled flags, gated globally
`ifndef CID_DEFS_VH
`define CID_DEFS_VH

`define CID_CLK_HZ 25000000
`define CID_QDIV 2'h3
`define CID_VECTOR 15'h0004

`define CID_A_CTRL 8'h00
`define CID_A_PFA 8'h04
`define CID_A_PFB 8'h08
`define CID_A_PEA 8'h0C
`define CID_A_PEB 8'h10
`define CID_A_CFG 8'h14
`define CID_A_ISTAT 8'h18
`define CID_A_IMASK 8'h1C
`define CID_A_STATE 8'h20

`define CID_B_GIE 7
`define CID_B_PERIPH_GROUP_IRQ_ENABLE 6
`define CID_B_CFG_RISE 0
`define CID_CFG_RST 8'h01
`define CID_NFLAG 19

`define CID_EV_ENTRY 0
`define CID_EV_RET 1
`define CID_EV_WAKE 2

`define CID_RESP_OK 2'h0
`define CID_RESP_ERR 2'h2

`endif

// ### rtl/cid_shadow.v
// Purpose: shadow copy of the core context
// Assumes: save is a one-cycle pulse from the dispatcher
// Notes: holds value between saves; cleared by reset
`timescale 1ns/1ps
module cid_shadow (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Context in
  input wire save,
  input wire [54:0] ctx_in,
  // Context out
  output reg [54:0] ctx_ff
);

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctx_ff <= 55'h0;
    end else if (save) begin
      ctx_ff <= ctx_in; // see [R11]
    end
  end

endmodule

// ### rtl/cid_dispatch.v
// Purpose: interrupt flags, enables and vectoring sequence of the core
// Assumes: core inputs share aclk; ext_int_pin is asynchronous
// Notes: core acts on its control pulses at the cycle they are high
`timescale 1ns/1ps
`include "cid_defs.vh"
module cid_dispatch (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite slave
  input wire [7:0] s_awaddr,
  input wire s_awvalid,
  output wire s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output wire s_wready,
  output reg [1:0] s_bresp,
  output reg s_bvalid,
  input wire s_bready,
  input wire [7:0] s_araddr,
  input wire s_arvalid,
  output wire s_arready,
  output reg [31:0] s_rdata,
  output reg [1:0] s_rresp,
  output reg s_rvalid,
  input wire s_rready,
  // Event sources
  input wire ext_int_pin,
  input wire [1:0] core_evt,
  input wire [7:0] periph_evt_a,
  input wire [7:0] periph_evt_b,
  // Core sequencer
  output reg icyc_en,
  input wire return_from_irq_op,
  input wire sleeping,
  input wire [14:0] cur_pc,
  input wire [7:0] ctx_w,
  input wire [2:0] ctx_status_low,
  input wire [4:0] ctx_bsr,
  input wire [15:0] ctx_fsr0,
  input wire [15:0] ctx_fsr1,
  input wire [6:0] ctx_pc_high_latch,
  output reg flush_ff,
  output reg push_ff,
  output reg [14:0] push_addr_ff,
  output reg vec_load_ff,
  output reg [14:0] vec_addr_ff,
  output reg pop_ff,
  output reg restore_ff,
  output wire [54:0] restore_ctx,
  output reg wake_ff,
  output wire core_irq_req,
  // Interrupt
  output wire irq
);

  localparam ST_RUN = 3'b001;
  localparam ST_SAVE = 3'b010;
  localparam ST_VECT = 3'b100;

  ////////////////////////////////////////////////////////////////////
  // Registers
  reg [1:0] div_ff;
  reg [`CID_NFLAG-1:0] flags_ff;
  reg gie_ff;
  reg periph_group_irq_enable_ff;
  reg [2:0] core_en_ff;
  reg [7:0] pea_ff;
  reg [7:0] peb_ff;
  reg [7:0] cfg_ff;
  reg [2:0] istat_ff;
  reg [2:0] imask_ff;
  reg [2:0] state_ff;
  reg pin_s1_ff;
  reg pin_s2_ff;
  reg pin_s3_ff;
  reg slp_prev_ff;
  reg hold_ff;
  reg aw_got_ff;
  reg w_got_ff;
  reg [7:0] awaddr_ff;
  reg [7:0] wdata_ff;
  reg wstrb_ff;

  ////////////////////////////////////////////////////////////////////
  // Instruction cycle divider
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= 2'h0;
      icyc_en <= 1'b0;
    end else begin
      div_ff <= (div_ff == `CID_QDIV) ? 2'h0 : div_ff + 2'h1;
      icyc_en <= (div_ff == `CID_QDIV);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // External pin synchroniser and edge select
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_s3_ff <= 1'b0;
    end else begin
      pin_s1_ff <= ext_int_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  wire pin_edge = cfg_ff[`CID_B_CFG_RISE] ? (pin_s2_ff & ~pin_s3_ff) :
                  (~pin_s2_ff & pin_s3_ff);

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  assign s_awready = ~aw_got_ff & ~s_bvalid;
  assign s_wready = ~w_got_ff & ~s_bvalid;
  wire wr_fire = aw_got_ff & w_got_ff & ~s_bvalid;
  wire wr_ok = wr_fire & wstrb_ff;
  wire wr_ctrl = wr_ok & (awaddr_ff == `CID_A_CTRL);
  wire wr_pfa = wr_ok & (awaddr_ff == `CID_A_PFA);
  wire wr_pfb = wr_ok & (awaddr_ff == `CID_A_PFB);
  wire wr_pea = wr_ok & (awaddr_ff == `CID_A_PEA);
  wire wr_peb = wr_ok & (awaddr_ff == `CID_A_PEB);
  wire wr_cfg = wr_ok & (awaddr_ff == `CID_A_CFG);
  wire wr_imask = wr_ok & (awaddr_ff == `CID_A_IMASK);
  wire wr_mapped = (awaddr_ff == `CID_A_CTRL) |
                   (awaddr_ff == `CID_A_PFA) |
                   (awaddr_ff == `CID_A_PFB) |
                   (awaddr_ff == `CID_A_PEA) |
                   (awaddr_ff == `CID_A_PEB) |
                   (awaddr_ff == `CID_A_CFG) |
                   (awaddr_ff == `CID_A_ISTAT) |
                   (awaddr_ff == `CID_A_IMASK) |
                   (awaddr_ff == `CID_A_STATE);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      wstrb_ff <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= `CID_RESP_OK;
    end else begin
      if (s_awvalid & s_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_awaddr;
      end
      if (s_wvalid & s_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_wdata[7:0];
        wstrb_ff <= s_wstrb[0];
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_mapped ? `CID_RESP_OK : `CID_RESP_ERR;
      end else if (s_bvalid & s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Flags: one bit per source, event wins over a write
  wire [`CID_NFLAG-1:0] flag_evt = {periph_evt_b, periph_evt_a,
                                    core_evt, pin_edge};
  wire [`CID_NFLAG-1:0] flag_we = {{8{wr_pfb}}, {8{wr_pfa}},
                                   {3{wr_ctrl}}};
  wire [`CID_NFLAG-1:0] flag_wv = {wdata_ff, wdata_ff, wdata_ff[2:0]};

  genvar gi;
  generate
    for (gi = 0; gi < `CID_NFLAG; gi = gi + 1) begin : g_flag
      always @(posedge aclk) begin
        if (!aresetn) begin
          flags_ff[gi] <= 1'b0;
        end else begin
          flags_ff[gi] <= (flag_we[gi] ? flag_wv[gi] : flags_ff[gi]) |
                          flag_evt[gi]; // see [R03]
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Request forming
  wire core_hit = |(flags_ff[2:0] & core_en_ff);
  wire periph_hit = |(flags_ff[10:3] & pea_ff) |
                    |(flags_ff[18:11] & peb_ff);
  wire any_enabled = core_hit | (periph_group_irq_enable_ff & periph_hit); // see [R02]
  assign core_irq_req = gie_ff & any_enabled; // see [R13]

  ////////////////////////////////////////////////////////////////////
  // Dispatch sequencer
  wire can_take = icyc_en & ~sleeping & ~hold_ff;
  wire take = (state_ff == ST_RUN) & can_take & core_irq_req; // see [R07]
  wire do_ret = (state_ff == ST_RUN) & return_from_irq_op;
  wire wake_now = sleeping & any_enabled & ~wake_ff;

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_RUN;
      flush_ff <= 1'b0;
      push_ff <= 1'b0;
      push_addr_ff <= 15'h0000;
      vec_load_ff <= 1'b0;
      vec_addr_ff <= 15'h0000;
      pop_ff <= 1'b0;
      restore_ff <= 1'b0;
    end else begin
      flush_ff <= 1'b0;
      push_ff <= 1'b0;
      vec_load_ff <= 1'b0;
      pop_ff <= do_ret; // see [R06]
      restore_ff <= do_ret;
      case (state_ff)
        ST_RUN: begin
          if (take) begin
            flush_ff <= 1'b1; // see [R04]
            push_addr_ff <= cur_pc;
            state_ff <= ST_SAVE;
          end
        end
        ST_SAVE: begin
          if (icyc_en) begin
            push_ff <= 1'b1;
            state_ff <= ST_VECT;
          end
        end
        ST_VECT: begin
          if (icyc_en) begin
            vec_load_ff <= 1'b1; // see [R10]
            vec_addr_ff <= `CID_VECTOR;
            state_ff <= ST_RUN;
          end
        end
        default: begin
          state_ff <= ST_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sleep wake and one-instruction hold after wake
  always @(posedge aclk) begin
    if (!aresetn) begin
      slp_prev_ff <= 1'b0;
      hold_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      slp_prev_ff <= sleeping;
      wake_ff <= wake_now | (wake_ff & sleeping);
      if (slp_prev_ff & ~sleeping) begin
        hold_ff <= 1'b1; // see [R12]
      end else if (icyc_en) begin
        hold_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Enables and configuration
  always @(posedge aclk) begin
    if (!aresetn) begin
      gie_ff <= 1'b0; // see [R01]
      periph_group_irq_enable_ff <= 1'b0;
      core_en_ff <= 3'h0;
      pea_ff <= 8'h00;
      peb_ff <= 8'h00;
      cfg_ff <= `CID_CFG_RST;
      imask_ff <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        periph_group_irq_enable_ff <= wdata_ff[`CID_B_PERIPH_GROUP_IRQ_ENABLE];
        core_en_ff <= wdata_ff[5:3];
      end
      if (take) begin
        gie_ff <= 1'b0; // see [R05]
      end else if (do_ret) begin
        gie_ff <= 1'b1; // see [R06]
      end else if (wr_ctrl) begin
        gie_ff <= wdata_ff[`CID_B_GIE];
      end
      if (wr_pea) begin
        pea_ff <= wdata_ff;
      end
      if (wr_peb) begin
        peb_ff <= wdata_ff;
      end
      if (wr_cfg) begin
        cfg_ff <= wdata_ff;
      end
      if (wr_imask) begin
        imask_ff <= wdata_ff[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Shadow context
  cid_shadow u_shadow (
    .aclk(aclk),
    .aresetn(aresetn),
    .save(take),
    .ctx_in({ctx_w, ctx_status_low, ctx_bsr, ctx_fsr0, ctx_fsr1,
             ctx_pc_high_latch}),
    .ctx_ff(restore_ctx)
  );

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path and event status
  assign s_arready = ~s_rvalid;
  wire rd_fire = s_arvalid & s_arready;
  wire rd_istat = rd_fire & (s_araddr == `CID_A_ISTAT);
  wire [2:0] ev_set = {wake_now, do_ret, take};
  reg [7:0] rd_val;
  reg rd_hit;

  always @* begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    case (s_araddr)
      `CID_A_CTRL: rd_val = {gie_ff, periph_group_irq_enable_ff, core_en_ff, flags_ff[2:0]};
      `CID_A_PFA: rd_val = flags_ff[10:3];
      `CID_A_PFB: rd_val = flags_ff[18:11];
      `CID_A_PEA: rd_val = pea_ff;
      `CID_A_PEB: rd_val = peb_ff;
      `CID_A_CFG: rd_val = cfg_ff;
      `CID_A_ISTAT: rd_val = {5'h00, istat_ff};
      `CID_A_IMASK: rd_val = {5'h00, imask_ff};
      `CID_A_STATE: rd_val = {3'h0, core_irq_req, sleeping, state_ff};
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= `CID_RESP_OK;
      istat_ff <= 3'h0;
    end else begin
      if (rd_fire) begin
        s_rvalid <= 1'b1;
        s_rdata <= {24'h00_0000, rd_val};
        s_rresp <= rd_hit ? `CID_RESP_OK : `CID_RESP_ERR;
      end else if (s_rvalid & s_rready) begin
        s_rvalid <= 1'b0;
      end
      istat_ff <= (rd_istat ? 3'h0 : istat_ff) | ev_set;
    end
  end

  assign irq = |(istat_ff & imask_ff);

endmodule

// ### verif/cid_props.sv
// Purpose: dispatch sequence checks
// Assumes: one clock, sync low reset
// Notes: bound to cid_dispatch
`timescale 1ns/1ps
module cid_props (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Core side
  input wire icyc_en,
  input wire sleeping,
  input wire return_from_irq_op,
  input wire [14:0] cur_pc,
  input wire [7:0] ctx_w,
  input wire [2:0] ctx_status_low,
  input wire [4:0] ctx_bsr,
  input wire [15:0] ctx_fsr0,
  input wire [15:0] ctx_fsr1,
  input wire [6:0] ctx_pc_high_latch,
  // Dispatch outputs
  input wire flush_ff,
  input wire push_ff,
  input wire [14:0] push_addr_ff,
  input wire vec_load_ff,
  input wire [14:0] vec_addr_ff,
  input wire pop_ff,
  input wire restore_ff,
  input wire [54:0] restore_ctx,
  input wire wake_ff,
  input wire core_irq_req,
  input wire irq
);
  wire [54:0] live = {ctx_w, ctx_status_low, ctx_bsr, ctx_fsr0,
    ctx_fsr1, ctx_pc_high_latch};
  reg [54:0] sav_ff;
  // Context as it stood at the take edge
  always @(posedge aclk) begin
    if (!aresetn)
      sav_ff <= 55'h0;
    else if (flush_ff)
      sav_ff <= $past(live);
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_entry;
    ##4 push_ff ##4 vec_load_ff;
  endsequence
  chk_take_cause: assert property (
    flush_ff |-> $past(core_irq_req) && $past(icyc_en) &&
    !$past(sleeping)) else $error("take cause");
  chk_entry_order: assert property (
    flush_ff |-> s_entry) else $error("entry order");
  chk_vec_value: assert property (
    vec_load_ff |-> vec_addr_ff == 15'h0004)
    else $error("vector address");
  chk_push_value: assert property (
    flush_ff |-> push_addr_ff == $past(cur_pc))
    else $error("pushed address");
  chk_gie_dropped: assert property (
    flush_ff |-> !core_irq_req [*8]) else $error("request during entry");
  chk_ret_pair: assert property (
    pop_ff |-> restore_ff && $past(return_from_irq_op))
    else $error("return pulses");
  chk_ctx_restore: assert property (
    restore_ff |-> restore_ctx == sav_ff) else $error("restored context");
  chk_reset_idle: assert property (
    $rose(aresetn) |-> !core_irq_req && !irq)
    else $error("request after reset");
  chk_wake_cause: assert property (
    $rose(wake_ff) |-> $past(sleeping)) else $error("wake outside sleep");
endmodule
bind cid_dispatch cid_props cid_props_i (.*);

// ### verif/cid_core_model.sv
// Purpose: core sequencer model
// Assumes: dispatcher pulses last one aclk
// Notes: vectoring inverts context so a restore shows
`timescale 1ns/1ps
module cid_core_model #(
  parameter [54:0] CTX0 = 55'h52_3456_789A_BCDE
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Dispatcher
  input wire icyc_en,
  input wire push_ff,
  input wire [14:0] push_addr_ff,
  input wire vec_load_ff,
  input wire [14:0] vec_addr_ff,
  input wire pop_ff,
  input wire restore_ff,
  input wire [54:0] restore_ctx,
  // Bench command and core state
  input wire ret_req,
  output wire return_from_irq_op,
  output reg [14:0] pc_ff,
  output reg [54:0] ctx_ff
);
  reg [14:0] stk_ff;
  reg ret_ff;
  assign return_from_irq_op = ret_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      pc_ff <= 15'h0100;
      stk_ff <= 15'h0000;
      ctx_ff <= CTX0;
      ret_ff <= 1'h0;
    end else begin
      ret_ff <= ret_req;
      if (push_ff)
        stk_ff <= push_addr_ff;
      if (vec_load_ff)
        pc_ff <= vec_addr_ff;
      else if (pop_ff)
        pc_ff <= stk_ff;
      else if (icyc_en)
        pc_ff <= pc_ff + 15'h0001;
      if (vec_load_ff)
        ctx_ff <= ~ctx_ff;
      else if (restore_ff)
        ctx_ff <= restore_ctx;
    end
  end
endmodule

// ### verif/cid_dispatch_bench.sv
// Purpose: self-checking bench for cid_dispatch
// Assumes: 25 MHz aclk, AXI4-Lite master tasks
// Notes: reset checks first, then table rows, entry and return
`timescale 1ns/1ps
`include "cid_defs.vh"
module cid_dispatch_bench;
  localparam [54:0] CTX0 = 55'h52_3456_789A_BCDE;
  localparam [1:0] OK = `CID_RESP_OK;
  reg aclk = 1'h0, aresetn = 1'h0, sleeping = 1'h0, ret_req = 1'h0;
  reg [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  reg [31:0] s_wdata = 32'h0000_0000;
  reg [3:0] s_wstrb = 4'hF;
  reg s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
  reg s_arvalid = 1'h0, s_rready = 1'h0, ext_int_pin = 1'h0;
  reg [1:0] core_evt = 2'h0;
  reg [7:0] periph_evt_a = 8'h00, periph_evt_b = 8'h00;
  wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid, icyc_en, irq;
  wire flush_ff, push_ff, vec_load_ff, pop_ff, restore_ff, wake_ff;
  wire core_irq_req, return_from_irq_op;
  wire [1:0] s_bresp, s_rresp;
  wire [31:0] s_rdata;
  wire [14:0] cur_pc, push_addr_ff, vec_addr_ff;
  wire [54:0] restore_ctx, mctx;
  wire [7:0] ctx_w = mctx[54:47];
  wire [2:0] ctx_status_low = mctx[46:44];
  wire [4:0] ctx_bsr = mctx[43:39];
  wire [15:0] ctx_fsr0 = mctx[38:23], ctx_fsr1 = mctx[22:7];
  wire [6:0] ctx_pc_high_latch = mctx[6:0];
  // Row: control, periph enable, events, flag address, flag value
  logic [39:0] rows [7] = '{40'h10_0001_0012, 40'h90_0081_0092,
    40'h80_0001_0082, 40'h80_0102_0401, 40'hC0_0182_0401,
    40'hC0_0002_0401, 40'h88_0084_0089};
  int bad_count = 0, cmp_count = 0, takes = 0, t0, n;
  reg [14:0] ret_pc = 15'h0000;
  always #20 aclk = ~aclk;
  // Model already stepped its PC at the take edge
  always @(posedge aclk) begin
    if (flush_ff) begin
      takes <= takes + 1;
      ret_pc <= cur_pc - 15'h0001;
    end
  end
  cid_dispatch cid_dispatch_i (.*);
  cid_core_model #(.CTX0(CTX0)) cid_core_model_i (.*, .pc_ff(cur_pc),
    .ctx_ff(mctx));
  task complete_run;
    $display("Checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bounded clock step
  task step;
    n++;
    if (n > 60) begin
      chk("wait", 1, 0);
      complete_run;
    end
    @(posedge aclk);
  endtask
  task wr(input [7:0] a, input [7:0] d, input [1:0] er);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= {24'h00_0000, d};
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    n = 0;
    do begin
      step;
      if (s_awready) s_awvalid <= 1'h0;
      if (s_wready) s_wvalid <= 1'h0;
    end while (!s_bvalid);
    s_bready <= 1'h0;
    chk("bresp", er, s_bresp);
  endtask
  task rd(input [7:0] a, input [31:0] e, input [1:0] er);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    n = 0;
    do begin
      step;
      if (s_arready) s_arvalid <= 1'h0;
    end while (!s_rvalid);
    s_rready <= 1'h0;
    chk("rdata", e, s_rdata);
    chk("rresp", er, s_rresp);
  endtask
  task pulse(input [7:0] e);
    @(posedge aclk);
    core_evt <= {1'h0, e[0]};
    periph_evt_a <= {7'h00, e[1]};
    ext_int_pin <= e[2];
    @(posedge aclk);
    core_evt <= 2'h0;
    periph_evt_a <= 8'h00;
    repeat (4) @(posedge aclk);
    ext_int_pin <= 1'h0;
    @(negedge aclk);
  endtask
  task ret_isr;
    @(posedge aclk);
    ret_req <= 1'h1;
    @(posedge aclk);
    ret_req <= 1'h0;
    n = 0;
    while (!pop_ff) step;
    @(negedge aclk);
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`CID_A_CTRL, 32'h0000_0000, OK);
    rd(`CID_A_CFG, {24'h00_0000, `CID_CFG_RST}, OK);
    rd(8'h24, 32'h0000_0000, `CID_RESP_ERR);
    wr(8'h24, 8'h00, `CID_RESP_ERR);
    wr(`CID_A_IMASK, 8'h07, OK);
    $display("Test reset done");
    // Asleep, so no take while rows run
    sleeping <= 1'h1;
    for (int i = 0; i < 7; i++) begin
      wr(`CID_A_PFA, 8'h00, OK);
      wr(`CID_A_PEA, rows[i][31:24], OK);
      wr(`CID_A_CTRL, rows[i][39:32], OK);
      pulse(rows[i][23:16]);
      chk("request", rows[i][23], core_irq_req);
      rd(rows[i][15:8], {24'h00_0000, rows[i][7:0]}, OK);
    end
    chk("wake", 1'h1, wake_ff);
    wr(`CID_A_CTRL, 8'h00, OK);
    sleeping <= 1'h0;
    $display("Test table done");
    wr(`CID_A_CTRL, 8'h90, OK);
    pulse(8'h01);
    n = 0;
    while (!vec_load_ff) step;
    chk("latency", 1'h1, n + 3 <= 16);
    t0 = takes;
    pulse(8'h01);
    repeat (12) @(posedge aclk);
    chk("nested take", t0, takes);
    rd(`CID_A_CTRL, 32'h0000_0012, OK);
    rd(`CID_A_ISTAT, 32'h0000_0005, OK);
    @(negedge aclk);
    chk("irq", 1'h0, irq);
    wr(`CID_A_CTRL, 8'h10, OK);
    ret_isr;
    chk("pc", ret_pc, cur_pc);
    chk("ctx", CTX0[38:7], {ctx_fsr0, ctx_fsr1});
    chk("ctx w", CTX0[54:47], ctx_w);
    rd(`CID_A_CTRL, 32'h0000_0090, OK);
    $display("Test entry done");
    wr(`CID_A_CTRL, 8'h10, OK);
    pulse(8'h01);
    t0 = takes;
    repeat (8) @(posedge aclk);
    chk("held take", t0, takes);
    wr(`CID_A_CTRL, 8'h92, OK);
    n = 0;
    while (!vec_load_ff) step;
    chk("late take", t0 + 1, takes);
    wr(`CID_A_CTRL, 8'h10, OK);
    ret_isr;
    $display("Test pending done");
    // Falling edge mode: rise ignored, fall flags
    wr(`CID_A_CFG, 8'h00, OK);
    wr(`CID_A_CTRL, 8'h08, OK);
    pulse(8'h04);
    rd(`CID_A_CTRL, 32'h0000_0008, OK);
    rd(`CID_A_CTRL, 32'h0000_0009, OK);
    $display("Test falling edge done");
    // Reset while a request and irq stand
    sleeping <= 1'h1;
    wr(`CID_A_CTRL, 8'h90, OK);
    pulse(8'h01);
    chk("request", 1'h1, core_irq_req);
    @(posedge aclk);
    aresetn <= 1'h0;
    sleeping <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`CID_A_CTRL, 32'h0000_0000, OK);
    rd(`CID_A_STATE, 32'h0000_0001, OK);
    chk("irq", 1'h0, irq);
    $display("Test second reset done");
    complete_run;
  end
endmodule
